// [inc/cfss_pkg.sv]
package cfss_pkg;
  localparam int unsigned PC_W        = 13;
  localparam int unsigned STACK_DEPTH = 8;
  localparam logic [3:0]  STACK_FULL  = 4'h8;
  localparam logic [3:0]  STACK_EMPTY = 4'h0;

  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [12:0] INT_VECTOR   = 13'h0004;
  localparam logic [3:0]  FLAGS_RESET  = 4'h0;
  localparam logic [3:0]  PHASE_RESET  = 4'h1;

  localparam logic [7:0]  OFS_PC_LOW_BYTE = 8'h00;
  localparam logic [7:0]  OFS_ACC         = 8'h04;
  localparam logic [7:0]  OFS_STATUS      = 8'h08;
  localparam logic [2:0]  HSIZE_WORD      = 3'h2;

  localparam int unsigned FLAG_Z   = 0;
  localparam int unsigned FLAG_C   = 1;
  localparam int unsigned FLAG_AC  = 2;
  localparam int unsigned FLAG_OV  = 3;
  localparam int unsigned ST_PEND  = 4;
  localparam int unsigned ST_IEN   = 5;
  localparam int unsigned IRET_BIT = 0;

  typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} cfss_phase_t;

  typedef enum logic [1:0] {
    REG_LOW_BYTE, REG_ACC, REG_STATUS, REG_NONE
  } cfss_reg_t;

  typedef enum logic [2:0] {
    OP_NOP, OP_ALU, OP_SKIPZ, OP_UNCOND_JUMP, OP_CALL, OP_RETURN,
    OP_WRITE_LOWBYTE, OP_EXT
  } cfss_op_t;

  typedef enum logic [3:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_XOR,
    ALU_CPL, ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_INC, ALU_DEC, ALU_MOV
  } cfss_alu_op_t;

  typedef struct packed {
    cfss_op_t    op;
    logic [12:0] arg;
  } cfss_instr_t;

  typedef struct packed {
    logic [7:0] result;
    logic [3:0] flags;
  } cfss_alu_out_t;

  typedef struct packed {
    cfss_phase_t                       phase;
    logic [3:0]                        cyclePhases;
    logic [PC_W-1:0]                   pmAddr;
    cfss_instr_t                       fetchBuf;
    cfss_instr_t                       ir;
    logic                              irValid;
    logic                              extStage;
    logic [7:0]                        acc;
    logic [3:0]                        flags;
    logic [STACK_DEPTH-1:0][PC_W-1:0]  stack;
    logic [2:0]                        stkPtr;
    logic [3:0]                        stkCount;
    logic                              intPending;
    logic                              intEnabled;
    logic                              intAck;
    logic                              lowByteReq;
    logic [7:0]                        lowByteData;
    logic                              wrPend;
    cfss_reg_t                         wrReg;
    logic [31:0]                       hrdata;
    logic                              hreadyout;
    logic                              hresp;
  } cfss_state_t;
endpackage

// [rtl/cfss_alu.sv]
`timescale 1ns/1ns
module cfss_alu (
  input  wire cfss_pkg::cfss_alu_op_t  op,
  input  wire logic [7:0]              a,
  input  wire logic [7:0]              b,
  input  wire logic [3:0]              flagsIn,
  output cfss_pkg::cfss_alu_out_t      res
);
  function automatic logic [9:0] addc(input logic [7:0] x,
                                      input logic [7:0] y,
                                      input logic       ci);
    logic [4:0] lo;
    logic [8:0] full;
    begin
      lo   = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
      full = {1'b0, x} + {1'b0, y} + {8'h00, ci};
      return {lo[4], full};
    end
  endfunction

  logic [9:0] sum;
  logic [7:0] bb;
  logic [7:0] r;
  logic [3:0] f;
  logic       ci;
  logic       arith;
  logic       zAffect;

  always_comb begin
    r       = a;
    f       = flagsIn;
    bb      = b;
    ci      = 1'b0;
    arith   = 1'b0;
    zAffect = 1'b1;
    sum     = 10'h000;
    // 8-bit operations on accumulator and operand
    unique case (op)
      cfss_pkg::ALU_ADD: arith = 1'b1;
      cfss_pkg::ALU_ADC: begin
        arith = 1'b1;
        ci    = flagsIn[cfss_pkg::FLAG_C];
      end
      cfss_pkg::ALU_SUB: begin
        arith = 1'b1;
        bb    = ~b;
        ci    = 1'b1;
      end
      cfss_pkg::ALU_SBC: begin
        arith = 1'b1;
        bb    = ~b;
        ci    = flagsIn[cfss_pkg::FLAG_C];
      end
      cfss_pkg::ALU_AND: r = a & b;
      cfss_pkg::ALU_OR:  r = a | b;
      cfss_pkg::ALU_XOR: r = a ^ b;
      cfss_pkg::ALU_CPL: r = ~a;
      cfss_pkg::ALU_RR: begin
        r       = {a[0], a[7:1]};
        zAffect = 1'b0;
      end
      cfss_pkg::ALU_RRC: begin
        r       = {flagsIn[cfss_pkg::FLAG_C], a[7:1]};
        f[cfss_pkg::FLAG_C] = a[0];
        zAffect = 1'b0;
      end
      cfss_pkg::ALU_RL: begin
        r       = {a[6:0], a[7]};
        zAffect = 1'b0;
      end
      cfss_pkg::ALU_RLC: begin
        r       = {a[6:0], flagsIn[cfss_pkg::FLAG_C]};
        f[cfss_pkg::FLAG_C] = a[7];
        zAffect = 1'b0;
      end
      cfss_pkg::ALU_INC: r = a + 8'h01;
      cfss_pkg::ALU_DEC: r = a - 8'h01;
      cfss_pkg::ALU_MOV: begin
        r       = b;
        zAffect = 1'b0;
      end
      default: zAffect = 1'b0;
    endcase
    if (arith) begin
      sum = addc(a, bb, ci);
      r   = sum[7:0];
      f[cfss_pkg::FLAG_C]  = sum[8];
      f[cfss_pkg::FLAG_AC] = sum[9];
      f[cfss_pkg::FLAG_OV] = (a[7] == bb[7]) && (r[7] != a[7]);
    end
    if (zAffect) begin
      f[cfss_pkg::FLAG_Z] = (r == 8'h00);
    end
    res.result = r;
    res.flags  = f;
  end
endmodule // cfss_alu

// [rtl/cfss_core.sv]
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns
// Functional notes
// - four non-overlapping phases form one cycle
// - counter steps at phase one, fetch then
// - fetch overlaps execute; extended takes two
// - jumps and calls flush, one extra cycle
// - taken skip replaces next with dummy cycle
// - thirteen-bit counter, only low byte visible
// - low byte write jumps within page
// - step by one, else load target
// - eight-level stack hidden from software
// - call and interrupt push, returns pop
// - reset empties the stack
// - full stack records interrupt, withholds acknowledge
// - call on full stack loses oldest
// - eight-bit ALU through the accumulator
// - ALU results update status flags
// - reset starts execution at address zero
module cfss_core (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output logic [12:0]      pmAddr,
  input  wire logic [15:0] pmData,
  input  wire logic        intReq,
  output logic             intAck,
  output logic [3:0]       cyclePhasesOneToFour
);
  cfss_pkg::cfss_state_t   s;
  cfss_pkg::cfss_state_t   next_s;
  cfss_pkg::cfss_alu_out_t aluOut;
  cfss_pkg::cfss_reg_t     addrReg;
  logic                    boundary;
  logic                    extHold;
  logic                    doJump;
  logic                    doSkip;
  logic                    doPush;
  logic                    doPop;
  logic                    ackNow;
  logic [12:0]             target;
  logic [12:0]             topOfStack;

  function automatic logic [3:0] phaseOneHot(
    input cfss_pkg::cfss_phase_t p);
    return 4'h1 << p;
  endfunction

  function automatic cfss_pkg::cfss_reg_t decodeReg(
    input logic [31:0] a);
    if (a[31:8] != 24'h000000) begin
      return cfss_pkg::REG_NONE;
    end
    unique case (a[7:0])
      cfss_pkg::OFS_PC_LOW_BYTE: return cfss_pkg::REG_LOW_BYTE;
      cfss_pkg::OFS_ACC:         return cfss_pkg::REG_ACC;
      cfss_pkg::OFS_STATUS:      return cfss_pkg::REG_STATUS;
      default:                   return cfss_pkg::REG_NONE;
    endcase
  endfunction

  assign boundary   = (s.phase == cfss_pkg::PH_T4);
  assign topOfStack = s.stack[s.stkPtr - 3'h1];
  assign extHold    = s.irValid && (s.ir.op == cfss_pkg::OP_EXT) &&
                      !s.extStage;
  assign addrReg    = decodeReg(haddr);

  cfss_alu u_alu (
    .op      (cfss_pkg::cfss_alu_op_t'(s.ir.arg[11:8])),
    .a       (s.acc),
    .b       (s.ir.arg[7:0]),
    .flagsIn (s.flags),
    .res     (aluOut)
  );

  always_comb begin
    next_s = s;
    next_s.intAck = 1'b0;
    doJump = 1'b0;
    doSkip = 1'b0;
    doPush = 1'b0;
    doPop  = 1'b0;
    ackNow = 1'b0;
    target = s.pmAddr;
    // phase ring
    unique case (s.phase)
      cfss_pkg::PH_T1: next_s.phase = cfss_pkg::PH_T2;
      cfss_pkg::PH_T2: next_s.phase = cfss_pkg::PH_T3;
      cfss_pkg::PH_T3: next_s.phase = cfss_pkg::PH_T4;
      cfss_pkg::PH_T4: next_s.phase = cfss_pkg::PH_T1;
    endcase
    next_s.cyclePhases = phaseOneHot(next_s.phase);
    if (s.phase == cfss_pkg::PH_T1) begin
      next_s.fetchBuf = cfss_pkg::cfss_instr_t'(pmData);
    end
    // execution commits at the end of phase four
    if (boundary) begin
      next_s.pmAddr  = s.pmAddr + 13'h0001;
      next_s.ir      = s.fetchBuf;
      next_s.irValid = 1'b1;
      if (s.irValid) begin
        unique case (s.ir.op)
          cfss_pkg::OP_NOP: begin
          end
          cfss_pkg::OP_ALU: begin
            next_s.acc   = aluOut.result;
            next_s.flags = aluOut.flags;
          end
          cfss_pkg::OP_SKIPZ: begin
            doSkip = (aluOut.result == 8'h00);
          end
          cfss_pkg::OP_UNCOND_JUMP: begin
            doJump = 1'b1;
            target = s.ir.arg;
          end
          cfss_pkg::OP_CALL: begin
            doPush = 1'b1;
            doJump = 1'b1;
            target = s.ir.arg;
          end
          cfss_pkg::OP_RETURN: begin
            doPop  = 1'b1;
            doJump = 1'b1;
            target = topOfStack;
            if (s.ir.arg[cfss_pkg::IRET_BIT]) begin
              next_s.intEnabled = 1'b1;
            end
          end
          cfss_pkg::OP_WRITE_LOWBYTE: begin
            doJump = 1'b1;
            target = {s.pmAddr[12:8], s.acc};
          end
          cfss_pkg::OP_EXT: begin
            if (!s.extStage) begin
              next_s.extStage = 1'b1;
              next_s.ir.op    = s.ir.op;
              next_s.ir.arg   = {s.ir.arg[12:8], s.fetchBuf.arg[7:0]};
            end else begin
              next_s.extStage = 1'b0;
              next_s.acc      = aluOut.result;
              next_s.flags    = aluOut.flags;
            end
          end
        endcase
      end
      // software write of the low byte
      if (!doJump && !extHold && s.lowByteReq) begin
        doJump = 1'b1;
        target = {s.pmAddr[12:8], s.lowByteData};
        next_s.lowByteReq = 1'b0;
      end
      ackNow = s.intPending && s.intEnabled && !doJump && !doSkip &&
               !extHold && (s.stkCount != cfss_pkg::STACK_FULL);
      if (ackNow) begin
        doPush = 1'b1;
        doJump = 1'b1;
        target = cfss_pkg::INT_VECTOR;
        next_s.intEnabled = 1'b0;
        next_s.intAck     = 1'b1;
      end
      // stack is reached only by call, acknowledge and return
      if (doPush) begin
        next_s.stack[s.stkPtr] = s.pmAddr;
        next_s.stkPtr = s.stkPtr + 3'h1;
        if (s.stkCount != cfss_pkg::STACK_FULL) begin
          next_s.stkCount = s.stkCount + 4'h1;
        end
      end
      if (doPop) begin
        next_s.stkPtr = s.stkPtr - 3'h1;
        if (s.stkCount != cfss_pkg::STACK_EMPTY) begin
          next_s.stkCount = s.stkCount - 4'h1;
        end
      end
      if (doJump) begin
        next_s.pmAddr   = target;
        next_s.irValid  = 1'b0;
        next_s.extStage = 1'b0;
      end
      if (doSkip) begin
        next_s.irValid = 1'b0;
      end
    end
    next_s.intPending = intReq | (s.intPending & ~ackNow);
    // bus slave, zero wait states
    next_s.hreadyout = 1'b1;
    next_s.hresp     = 1'b0;
    if (s.wrPend) begin
      unique case (s.wrReg)
        cfss_pkg::REG_LOW_BYTE: begin
          next_s.lowByteReq  = 1'b1;
          next_s.lowByteData = hwdata[7:0];
        end
        cfss_pkg::REG_ACC:    next_s.acc   = hwdata[7:0];
        cfss_pkg::REG_STATUS: next_s.flags = hwdata[3:0];
        cfss_pkg::REG_NONE: begin
        end
      endcase
    end
    next_s.wrPend = 1'b0;
    if (hsel && htrans[1] && hready) begin
      next_s.wrPend = hwrite && (hsize == cfss_pkg::HSIZE_WORD);
      next_s.wrReg  = addrReg;
      next_s.hrdata = 32'h00000000;
      if (!hwrite) begin
        unique case (addrReg)
          cfss_pkg::REG_LOW_BYTE: next_s.hrdata[7:0] = s.pmAddr[7:0];
          cfss_pkg::REG_ACC:      next_s.hrdata[7:0] = s.acc;
          cfss_pkg::REG_STATUS: begin
            next_s.hrdata[3:0] = s.flags;
            next_s.hrdata[cfss_pkg::ST_PEND] = s.intPending;
            next_s.hrdata[cfss_pkg::ST_IEN]  = s.intEnabled;
          end
          cfss_pkg::REG_NONE: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s             <= '0;
      s.pmAddr      <= cfss_pkg::RESET_VECTOR;
      s.flags       <= cfss_pkg::FLAGS_RESET;
      s.cyclePhases <= cfss_pkg::PHASE_RESET;
      s.intEnabled  <= 1'b1;
      s.hreadyout   <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout            = s.hreadyout;
  assign hrdata               = s.hrdata;
  assign hresp                = s.hresp;
  assign pmAddr               = s.pmAddr;
  assign intAck               = s.intAck;
  assign cyclePhasesOneToFour = s.cyclePhases;

  sequence s_extFirst;
    boundary && extHold;
  endsequence

  sequence s_freeLevel;
    boundary && s.irValid && s.ir.op == cfss_pkg::OP_RETURN &&
    s.stkCount == cfss_pkg::STACK_FULL && s.intPending && s.intEnabled;
  endsequence

  a_phase_ring: assert property (@(posedge clk) disable iff (srst)
    s.phase == cfss_pkg::PH_T4 |=> s.phase == cfss_pkg::PH_T1 ##1
    s.phase == cfss_pkg::PH_T2 ##1 s.phase == cfss_pkg::PH_T3)
    else $error("phase ring broken");

  a_seq_step: assert property (@(posedge clk) disable iff (srst)
    boundary && !doJump |=> s.pmAddr == $past(s.pmAddr) + 13'h0001)
    else $error("program counter did not step by one");

  a_ext_two: assert property (@(posedge clk) disable iff (srst)
    s_extFirst |=> s.extStage [*4] ##1 !s.extStage)
    else $error("extended instruction not two cycles");

  a_jump_flush: assert property (@(posedge clk) disable iff (srst)
    boundary && s.irValid && s.ir.op == cfss_pkg::OP_UNCOND_JUMP
    |=> !s.irValid && s.pmAddr == $past(s.ir.arg))
    else $error("jump did not flush to target");

  a_skip_dummy: assert property (@(posedge clk) disable iff (srst)
    boundary && doSkip |=> !s.irValid ##4 s.irValid)
    else $error("skip did not insert one dummy cycle");

  a_page_jump: assert property (@(posedge clk) disable iff (srst)
    boundary && s.irValid && s.ir.op == cfss_pkg::OP_WRITE_LOWBYTE
    |=> s.pmAddr == {$past(s.pmAddr[12:8]), $past(s.acc)} && !s.irValid)
    else $error("low byte jump left the page");

  a_ret_pop: assert property (@(posedge clk) disable iff (srst)
    boundary && s.irValid && s.ir.op == cfss_pkg::OP_RETURN
    |=> s.pmAddr == $past(topOfStack))
    else $error("return did not restore the counter");

  a_reset_empty: assert property (@(posedge clk)
    srst |=> s.stkCount == cfss_pkg::STACK_EMPTY &&
    s.pmAddr == cfss_pkg::RESET_VECTOR)
    else $error("reset did not empty stack and zero counter");

  a_full_defer: assert property (@(posedge clk) disable iff (srst)
    s.stkCount == cfss_pkg::STACK_FULL |=> !s.intAck)
    else $error("acknowledge given with stack full");

  a_call_overflow: assert property (@(posedge clk) disable iff (srst)
    boundary && s.irValid && s.ir.op == cfss_pkg::OP_CALL &&
    s.stkCount == cfss_pkg::STACK_FULL
    |=> s.stkCount == cfss_pkg::STACK_FULL &&
    s.stkPtr == $past(s.stkPtr) + 3'h1)
    else $error("overflowing call mishandled");

  a_flag_update: assert property (@(posedge clk) disable iff (srst)
    boundary && s.irValid && s.ir.op == cfss_pkg::OP_ALU && !s.wrPend
    |=> s.flags == $past(aluOut.flags) && s.acc == $past(aluOut.result))
    else $error("ALU result or flags not committed");

  a_late_ack: assert property (@(posedge clk) disable iff (srst)
    s_freeLevel |-> ##5 s.intAck)
    else $error("deferred acknowledge not granted after return");

  a_phase_onehot: assert property (@(posedge clk) disable iff (srst)
    $onehot(s.cyclePhases) && s.cyclePhases == phaseOneHot(s.phase))
    else $error("phase outputs not one-hot");

  a_ext_hold: assert property (@(posedge clk) disable iff (srst)
    s_extFirst |=> s.irValid && s.ir.op == cfss_pkg::OP_EXT &&
    s.pmAddr == $past(s.pmAddr) + 13'h0001)
    else $error("extended first half not held");

  a_call_push: assert property (@(posedge clk) disable iff (srst)
    boundary && s.irValid && s.ir.op == cfss_pkg::OP_CALL
    |=> topOfStack == $past(s.pmAddr) &&
    s.pmAddr == $past(s.ir.arg) && !s.irValid)
    else $error("call did not push and branch");

  a_ack_vector: assert property (@(posedge clk) disable iff (srst)
    boundary && ackNow
    |=> s.intAck && s.pmAddr == cfss_pkg::INT_VECTOR && !s.intEnabled &&
    topOfStack == $past(s.pmAddr))
    else $error("acknowledge did not push and vector");

  a_stack_bound: assert property (@(posedge clk) disable iff (srst)
    s.stkCount <= cfss_pkg::STACK_FULL)
    else $error("stack level count beyond eight");

  a_ack_level: assert property (@(posedge clk) disable iff (srst)
    s.intAck |-> $past(s.stkCount) != cfss_pkg::STACK_FULL)
    else $error("acknowledge taken from a full stack");
endmodule // cfss_core

// [sim/cfss_prog_mem.sv]
`timescale 1ns/1ns
module cfss_prog_mem (
  input  wire logic [12:0] pmAddr,
  output logic [15:0]      pmData
);
  logic [15:0] mem [0:8191];

  // unwritten words decode as no-operation
  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem[i] = 16'h0000;
    end
  end

  // asynchronous read, settled long before phase one ends
  assign pmData = mem[pmAddr];
endmodule // cfss_prog_mem

// [sim/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
  logic        clk;
  logic        srst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic [12:0] pmAddr;
  logic [15:0] pmData;
  logic        intReq;
  logic        intAck;
  logic [3:0]  phases;
  int          nMismatch;
  int          checked;
  logic [12:0] trace [$];
  logic [12:0] lastAddr;
  int          holdCnt;
  logic [3:0]  prevPh;
  logic        prevRst;
  logic        saw181;
  logic [31:0] rd;
  logic [12:0] expTrace [15] = '{13'h001, 13'h010, 13'h011, 13'h012,
    13'h013, 13'h014, 13'h040, 13'h041, 13'h014, 13'h015, 13'h030,
    13'h031, 13'h032, 13'h131, 13'h132};

  cfss_core u_cfss_core (
    .clk                  (clk),
    .srst                 (srst),
    .hsel                 (hsel),
    .haddr                (haddr),
    .htrans               (htrans),
    .hwrite               (hwrite),
    .hsize                (hsize),
    .hwdata               (hwdata),
    .hready               (hreadyout),
    .hreadyout            (hreadyout),
    .hrdata               (hrdata),
    .hresp                (hresp),
    .pmAddr               (pmAddr),
    .pmData               (pmData),
    .intReq               (intReq),
    .intAck               (intAck),
    .cyclePhasesOneToFour (phases)
  );

  cfss_prog_mem u_cfss_prog_mem (
    .pmAddr (pmAddr),
    .pmData (pmData)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, nMismatch);
    if (nMismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      nMismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic fail();
    nMismatch++;
    $display("mismatch at %0t: wait limit reached", $time);
    finish_test();
  endtask

  task automatic waitReady();
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (hreadyout === 1'b1) break;
    end
    if (n == 20) fail();
  endtask

  // one single word transfer; read data lands in rd
  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= cfss_pkg::HSIZE_WORD;
    waitReady();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    waitReady();
    rd = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask

  task automatic ld(input logic [12:0] a, input logic [15:0] w);
    u_cfss_prog_mem.mem[a] = w;
  endtask

  function automatic logic [15:0] ins(input cfss_pkg::cfss_op_t op,
                                      input logic [12:0] arg);
    return {op, arg};
  endfunction

  function automatic logic [15:0] alu(input cfss_pkg::cfss_alu_op_t f,
                                      input logic [7:0] imm);
    return {cfss_pkg::OP_ALU, 1'b0, f, imm};
  endfunction

  // phase rotation, fetch spacing and fetch trace
  always @(posedge clk) begin
    if (srst) begin
      lastAddr = 13'h0000;
      holdCnt = 0;
    end else begin
      if (prevRst) begin
        check({28'h0, phases}, 32'h1);
        check({19'h0, pmAddr}, {19'h0, cfss_pkg::RESET_VECTOR});
      end else begin
        check({28'h0, phases}, {28'h0, prevPh[2:0], prevPh[3]});
      end
      if (pmAddr !== lastAddr) begin
        check(32'(holdCnt), 32'h4);
        if (trace.size() < 15) trace.push_back(pmAddr);
        lastAddr = pmAddr;
        holdCnt = 1;
      end else begin
        holdCnt++;
      end
      if (pmAddr === 13'h0181) saw181 = 1'b1;
    end
    prevPh = phases;
    prevRst = srst;
  end

  initial begin
    int   n;
    logic seen;
    hsel <= 1'b0;
    haddr <= 32'h0;
    htrans <= 2'b00;
    hwrite <= 1'b0;
    hsize <= 3'h0;
    hwdata <= 32'h0;
    intReq <= 1'b0;
    srst <= 1'b1;
    saw181 = 1'b0;
    nMismatch = 0;
    checked = 0;
    prevRst = 1'b1;
    prevPh = 4'h0;
    #1;
    ld(13'h000, ins(cfss_pkg::OP_UNCOND_JUMP, 13'h0010));
    ld(13'h004, ins(cfss_pkg::OP_RETURN, 13'h0001));
    ld(13'h010, alu(cfss_pkg::ALU_MOV, 8'h30));
    ld(13'h011, {cfss_pkg::OP_SKIPZ, 1'b0, cfss_pkg::ALU_AND, 8'h00});
    ld(13'h012, ins(cfss_pkg::OP_UNCOND_JUMP, 13'h0050));
    ld(13'h013, ins(cfss_pkg::OP_CALL, 13'h0040));
    ld(13'h014, ins(cfss_pkg::OP_WRITE_LOWBYTE, 13'h0000));
    ld(13'h030, alu(cfss_pkg::ALU_ADD, 8'hD0));
    ld(13'h031, ins(cfss_pkg::OP_UNCOND_JUMP, 13'h0131));
    ld(13'h040, ins(cfss_pkg::OP_RETURN, 13'h0000));
    ld(13'h131, ins(cfss_pkg::OP_UNCOND_JUMP, 13'h0131));
    ld(13'h1F0, {cfss_pkg::OP_EXT, 1'b0, cfss_pkg::ALU_ADD, 8'h00});
    ld(13'h1F1, 16'h0011);
    ld(13'h1F2, ins(cfss_pkg::OP_UNCOND_JUMP, 13'h01F2));
    ld(13'h180, ins(cfss_pkg::OP_CALL, 13'h0190));
    ld(13'h190, ins(cfss_pkg::OP_CALL, 13'h0190));
    ld(13'h191, ins(cfss_pkg::OP_RETURN, 13'h0000));
    ld(13'h1A0, ins(cfss_pkg::OP_RETURN, 13'h0000));
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    repeat (80) @(posedge clk);
    // jump, skip, call, return and low byte write in one program
    check(32'(trace.size()), 32'd15);
    for (int i = 0; i < 15; i++) begin
      check({19'h0, trace[i]}, {19'h0, expTrace[i]});
    end
    ahb(1'b0, 32'(cfss_pkg::OFS_ACC), 32'h0);
    check(rd, 32'h0);
    ahb(1'b0, 32'(cfss_pkg::OFS_STATUS), 32'h0);
    check(rd, 32'h23);
    ahb(1'b1, 32'(cfss_pkg::OFS_ACC), 32'h5A);
    ahb(1'b0, 32'(cfss_pkg::OFS_ACC), 32'h0);
    check(rd, 32'h5A);
    ahb(1'b1, 32'(cfss_pkg::OFS_STATUS), 32'h3F);
    ahb(1'b0, 32'(cfss_pkg::OFS_STATUS), 32'h0);
    check(rd, 32'h2F);
    ahb(1'b1, 32'h0C, 32'hFF);
    ahb(1'b0, 32'h0C, 32'h0);
    check(rd, 32'h0);
    ahb(1'b0, 32'(cfss_pkg::OFS_PC_LOW_BYTE), 32'h0);
    check(rd & 32'hFFFFFFFC, 32'h30);
    // low byte write keeps the page
    ahb(1'b1, 32'(cfss_pkg::OFS_PC_LOW_BYTE), 32'hF0);
    repeat (32) @(posedge clk);
    check({19'h0, pmAddr & 13'h1FFE}, 32'h1F2);
    // extended add of the second word's immediate to the accumulator
    ahb(1'b0, 32'(cfss_pkg::OFS_ACC), 32'h0);
    check(rd, 32'h6B);
    // endless self call overflows the stack
    ahb(1'b1, 32'(cfss_pkg::OFS_PC_LOW_BYTE), 32'h80);
    repeat (120) @(posedge clk);
    intReq <= 1'b1;
    seen = 1'b0;
    repeat (40) begin
      @(posedge clk);
      if (intAck === 1'b1) seen = 1'b1;
    end
    check({31'h0, seen}, 32'h0);
    ahb(1'b0, 32'(cfss_pkg::OFS_STATUS), 32'h0);
    check(rd & 32'h30, 32'h30);
    ahb(1'b1, 32'(cfss_pkg::OFS_PC_LOW_BYTE), 32'hA0);
    saw181 = 1'b0;
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (intAck === 1'b1) break;
    end
    if (n == 64) fail();
    check({19'h0, pmAddr & 13'h1FFE}, {19'h0, cfss_pkg::INT_VECTOR});
    intReq <= 1'b0;
    repeat (200) @(posedge clk);
    check({31'h0, saw181}, 32'h0);
    finish_test();
  end
endmodule // tb_top
